// >>> dv/sample_fifo_readout_test.sv
`timescale 1ns/10ps
module sample_fifo_readout_test;
	logic clk_sys, link_clk, reset, link_req, link_ack, link_busy;
	logic afe_start, afe_done, fast_clk_on, int_out;
	sfr_pkg::sfr_req_t link_cmd;
	sfr_pkg::sfr_afe_t afe_res;
	logic [15:0] link_rdata, q, st;
	logic [5:0] afe_pulses;
	logic [13:0] eff_pulses;
	logic [19:0] v [4];
	int n_mismatch = 0;
	int tests_run = 0;
	int n_done = 0;
	int k;

	// ****************
	// clocks and instances
	// ****************
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		link_clk = 1'b0;
		#13;
		forever #40 link_clk = ~link_clk;
	end

	sfr_top #(.FIFO_BYTES(64), .SLOT_UNIT_CYC(4)) dut (.clk_sys(clk_sys), .reset(reset), .link_clk(link_clk),
		.link_req(link_req), .link_cmd(link_cmd), .link_ack(link_ack), .link_busy(link_busy),
		.link_rdata(link_rdata), .afe_start(afe_start), .afe_pulses(afe_pulses), .afe_done(afe_done),
		.afe_res(afe_res), .eff_pulses(eff_pulses), .fast_clk_on(fast_clk_on), .int_out(int_out));
	sfr_host host (.link_clk(link_clk), .link_ack(link_ack), .link_rdata(link_rdata), .link_req(link_req),
		.link_cmd(link_cmd));

	// converter stand-in, answers each start a few cycles later
	initial begin
		afe_done = 1'b0;
		afe_res = '0;
		forever begin
			@(negedge clk_sys iff afe_start === 1'b1);
			repeat (4) @(posedge clk_sys);
			afe_done <= 1'b1;
			afe_res <= sfr_pkg::sfr_afe_t'({v[3], v[2], v[1], v[0]});
			n_done++;
			@(posedge clk_sys);
			afe_done <= 1'b0;
			afe_res <= sfr_pkg::sfr_afe_t'(~afe_res);
		end
	end

	// ****************
	// helpers
	// ****************
	function automatic logic [15:0] clip(input logic [21:0] s);
		return (s > 22'h00FFFF) ? 16'hFFFF : s[15:0];
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host.acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		host.acc(1'b0, a, 16'h0000, q);
	endtask
	task automatic wait_int;
		int n;
		n = 0;
		while (int_out !== 1'b1 && n < 3000) begin
			@(negedge clk_sys);
			n++;
		end
		chk({15'h0, int_out}, 16'h0001);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		#2000000;
		n_mismatch++;
		print_verdict;
	end

	// ****************
	// test sequence
	// ****************
	initial begin
		reset = 1'b1;
		void'($urandom(76));
		for (k = 0; k < 4; k++) v[k] = 20'h0;
		repeat (2) @(posedge link_clk);
		reset <= 1'b0;
		rd(8'h48); chk(q, 16'h00FF);
		rd(8'h21); chk(q, 16'h0100);
		rd(8'h32); chk(q, 16'h0040);
		wr(8'h00, 16'h1234);
		rd(8'h00); chk(q, 16'h0000);
		chk({2'h0, eff_pulses}, 16'h0001);
		chk({15'h0, link_busy}, 16'h0000);
		$display("reset test done");
		// one gesture sample, channel zero beyond full scale
		for (k = 0; k < 4; k++) v[k] = 20'($urandom);
		v[0] = 20'hF1234;
		wr(8'h1F, 16'h0100);
		wr(8'h40, 16'h000F);
		wr(8'h48, 16'h00FE);
		wr(8'h45, 16'h0010);
		wr(8'h45, 16'h0018);
		wait_int;
		wr(8'h45, 16'h001F);
		for (k = 0; k < 4; k++) begin
			rd(k[7:0]); chk(q, clip({2'h0, v[k]}));
		end
		rd(8'h49);
		st = q;
		chk(q & 16'h80FF, 16'h0081);
		chk({14'h0, st[9:8]}, 16'h0000);
		wr(8'h49, 16'h0000);
		rd(8'h49); chk(q & 16'h00FF, 16'h0080);
		chk({15'h0, int_out}, 16'h0000);
		rd(8'h60); chk(q, 16'h0000);
		wr(8'h32, 16'h0F4F);
		chk({15'h0, fast_clk_on}, 16'h0001);
		for (k = st[14:10]; k > 0; k--) begin
			rd(8'h49); chk(q & 16'h0080, 16'h0080);
			rd(8'h60); chk(q, clip({2'h0, v[0]}));
			rd(8'h60); chk(q, clip({2'h0, v[1]}));
		end
		rd(8'h49); chk(q, 16'h0000);
		wr(8'h32, 16'h0040);
		$display("gesture fifo test done");
		// four summed samples at pulse count three
		for (k = 0; k < 4; k++) v[k] = 20'($urandom % 32'h8000);
		v[2] = 20'h0FFFF;
		wr(8'h21, 16'h0300);
		wr(8'h46, 16'h0020);
		n_done = 0;
		wr(8'h45, 16'h0018);
		chk({10'h0, afe_pulses}, 16'h0003);
		chk({2'h0, eff_pulses}, 16'h000C);
		wait_int;
		chk(16'(n_done), 16'h0004);
		rd(8'h00); chk(q, clip({v[0], 2'b00}));
		wr(8'h45, 16'h001F);
		for (k = 0; k < 4; k++) begin
			rd(k[7:0]); chk(q, clip({v[k], 2'b00}));
		end
		$display("averaging test done");
		// refused and real flush, then overflow with six byte packets
		wr(8'h49, 16'h0000);
		wr(8'h49, 16'h8000);
		rd(8'h49); chk(q & 16'h0080, 16'h0080);
		wr(8'h32, 16'h0F4F);
		wr(8'h49, 16'h8000);
		rd(8'h49); chk(q, 16'h0000);
		wr(8'h32, 16'h0040);
		wr(8'h46, 16'h0000);
		wr(8'h40, 16'h00F0);
		wr(8'h48, 16'h00FD);
		wr(8'h45, 16'h0030);
		wr(8'h45, 16'h0031);
		repeat (400) @(posedge clk_sys);
		wr(8'h45, 16'h003F);
		rd(8'h49); chk(q, 16'h3C82);
		chk({15'h0, int_out}, 16'h0001);
		$display("overflow test done");
		print_verdict;
	end
endmodule

// >>> dv/sfr_host.sv
`timescale 1ns/10ps
module sfr_host (
	input wire logic link_clk,
	input wire logic link_ack,
	input wire logic [15:0] link_rdata,
	output logic link_req,
	output sfr_pkg::sfr_req_t link_cmd
);
	// ****************
	// host side of the register link
	// ****************
	initial begin
		link_req = 1'b0;
		link_cmd = '0;
	end

	// one access, held up to the edge that samples the acknowledge, then released with a changed bus
	task automatic acc(input logic we, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		int n;
		n = 0;
		@(posedge link_clk);
		link_req <= 1'b1;
		link_cmd <= sfr_pkg::sfr_req_t'({we, a, d});
		do begin
			@(posedge link_clk);
			n++;
		end while (link_ack !== 1'b1 && n < 40);
		q = (n < 40) ? link_rdata : 16'hDEAD;
		link_req <= 1'b0;
		link_cmd <= sfr_pkg::sfr_req_t'(~link_cmd);
	endtask
endmodule

// >>> hdl/sfr_pkg.sv
package sfr_pkg;
	// Functional notes
	// - fifo threshold flag drops by itself once reads bring the level in words down to the threshold or below
	// - data port reads return packet bytes when the clock is forced, and each byte read frees fifo space
	// - mode value 0xF stops sampling and puts the sequencer in idle
	// - writing one to status bit 15 empties the fifo when idle with clock forced
	// - the active mode's result registers update together at the end of each output sample
	// - results are 16 bits, four gesture channels and three proximity values
	// - result registers clip at full scale instead of wrapping
	// - a zero mask bit enables its interrupt source, a one masks it
	// - an enabled sample interrupt is raised on each result register update
	// - status low byte shows which interrupt source fired
	// - writing zero to the status low byte clears the sticky sample flags; the fifo flag follows the level
	// - pulse count fields set the led pulses per internal sample per mode
	// - averaging fields set how many internal samples are summed per output
	// - effective pulses equal pulse count times number of summed samples
	// - output rate equals internal sample rate divided by number of summed samples
	// - frequency select picks the internal sample rate per mode
	// - a 64 byte fifo holds packets from either sampling mode
	// - packets are 4 bytes for gesture, 2 or 6 bytes for proximity
	// - a packet is stored only when it fits whole, otherwise dropped whole
	// - fifo flag rises when the stored level in words passes the threshold

	// ****************************************************************
	// register offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_RES_LAST = 8'h06;
	localparam logic [7:0] ADDR_FTH = 8'h1F;
	localparam logic [7:0] ADDR_PCG = 8'h21;
	localparam logic [7:0] ADDR_PCP = 8'h23;
	localparam logic [7:0] ADDR_CLK = 8'h32;
	localparam logic [7:0] ADDR_FREQ = 8'h40;
	localparam logic [7:0] ADDR_MODE = 8'h45;
	localparam logic [7:0] ADDR_AVG = 8'h46;
	localparam logic [7:0] ADDR_MASK = 8'h48;
	localparam logic [7:0] ADDR_STAT = 8'h49;
	localparam logic [7:0] ADDR_DATA = 8'h60;

	// ****************************************************************
	// field positions, codes and reset values
	// ****************************************************************
	localparam int MODE_LSB = 0;
	localparam int FMT_LSB = 4;
	localparam int FTH_LSB = 8;
	localparam int PC_LSB = 8;
	localparam int AVG_GEST_LSB = 4;
	localparam int AVG_PROX_LSB = 0;
	localparam int FREQ_GEST_LSB = 0;
	localparam int FREQ_PROX_LSB = 4;
	localparam int FLUSH_BIT = 15;
	localparam int CNT_LSB = 8;
	localparam logic [15:0] CLK_FORCE = 16'h0F4F;
	localparam logic [15:0] CLK_RST = 16'h0040;
	localparam logic [3:0] MODE_STBY = 4'h0;
	localparam logic [3:0] MODE_PROX = 4'h1;
	localparam logic [3:0] MODE_GEST = 4'h8;
	localparam logic [3:0] MODE_IDLE = 4'hF;
	localparam logic [3:0] FMT_GEST = 4'h1;
	localparam logic [3:0] FMT_PROX_I = 4'h2;
	localparam logic [3:0] FMT_PROX_IXY = 4'h3;
	localparam logic [2:0] PKT_GEST = 3'h4;
	localparam logic [2:0] PKT_PROX_I = 3'h2;
	localparam logic [2:0] PKT_PROX_IXY = 3'h6;
	localparam logic [7:0] MASK_RST = 8'hFF;
	localparam logic [5:0] PC_RST = 6'h01;
	localparam int AFE_W = 20;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [15:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic [3:0][AFE_W-1:0] ch;
	} sfr_afe_t;

	typedef enum logic [1:0] {SS_OFF, SS_TICK, SS_CONV} sfr_samp_t;
endpackage

// >>> hdl/sfr_top.sv
`timescale 1ns/10ps
module sfr_top #(
	parameter int FIFO_BYTES = 64,
	parameter int SLOT_UNIT_CYC = 32
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic link_clk,
	input wire logic link_req,
	input wire sfr_pkg::sfr_req_t link_cmd,
	output logic link_ack,
	output logic link_busy,
	output logic [15:0] link_rdata,
	output logic afe_start,
	output logic [5:0] afe_pulses,
	input wire logic afe_done,
	input wire sfr_pkg::sfr_afe_t afe_res,
	output logic [13:0] eff_pulses,
	output logic fast_clk_on,
	output logic int_out
);
	localparam int PTR_W = $clog2(FIFO_BYTES);
	localparam int CNT_W = PTR_W + 1;
	localparam int SUM_W = sfr_pkg::AFE_W + 7;

	// ****************************************************************
	// link side: request capture and answer return
	// ****************************************************************
	sfr_pkg::sfr_req_t cmd_l_r;
	logic rq_tgl_r;
	logic ak_l1_r;
	logic ak_l2_r;
	logic ak_l3_r;
	logic link_ack_r;
	logic link_busy_r;
	logic [15:0] link_rdata_r;
	logic ack_ev;
	logic ack_tgl_r;
	logic [15:0] sys_rdata_r;

	// answer seen once the returned toggle has settled
	assign ack_ev = ak_l2_r ^ ak_l3_r;

	// one request in flight; command held stable until answered
	// a request still standing in the ack cycle is the old one, so it is not taken again
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			cmd_l_r <= '0;
			rq_tgl_r <= 1'b0;
			ak_l1_r <= 1'b0;
			ak_l2_r <= 1'b0;
			ak_l3_r <= 1'b0;
			link_ack_r <= 1'b0;
			link_busy_r <= 1'b0;
			link_rdata_r <= 16'h0000;
		end else begin
			ak_l1_r <= ack_tgl_r;
			ak_l2_r <= ak_l1_r;
			ak_l3_r <= ak_l2_r;
			link_ack_r <= ack_ev;
			if (ack_ev) begin
				link_rdata_r <= sys_rdata_r;
				link_busy_r <= 1'b0;
			end else if (link_req && !link_busy_r && !link_ack_r) begin
				cmd_l_r <= link_cmd;
				rq_tgl_r <= ~rq_tgl_r;
				link_busy_r <= 1'b1;
			end
		end
	end

	assign link_ack = link_ack_r;
	assign link_busy = link_busy_r;
	assign link_rdata = link_rdata_r;

	// ****************************************************************
	// system side: access decode
	// ****************************************************************
	logic rq_s1_r;
	logic rq_s2_r;
	logic rq_s3_r;
	logic acc_go;
	logic wr_go;
	logic rd_go;
	logic [7:0] addr;
	logic [15:0] wdata;

	// command words are stable while the toggle travels
	assign acc_go = rq_s2_r ^ rq_s3_r;
	assign wr_go = acc_go & cmd_l_r.we;
	assign rd_go = acc_go & ~cmd_l_r.we;
	assign addr = cmd_l_r.addr;
	assign wdata = cmd_l_r.wdata;

	logic we_fth;
	logic we_pcg;
	logic we_pcp;
	logic we_clk;
	logic we_freq;
	logic we_mode;
	logic we_avg;
	logic we_mask;
	logic we_stat;

	// write strobes per register
	assign we_fth = wr_go && (addr == sfr_pkg::ADDR_FTH);
	assign we_pcg = wr_go && (addr == sfr_pkg::ADDR_PCG);
	assign we_pcp = wr_go && (addr == sfr_pkg::ADDR_PCP);
	assign we_clk = wr_go && (addr == sfr_pkg::ADDR_CLK);
	assign we_freq = wr_go && (addr == sfr_pkg::ADDR_FREQ);
	assign we_mode = wr_go && (addr == sfr_pkg::ADDR_MODE);
	assign we_avg = wr_go && (addr == sfr_pkg::ADDR_AVG);
	assign we_mask = wr_go && (addr == sfr_pkg::ADDR_MASK);
	assign we_stat = wr_go && (addr == sfr_pkg::ADDR_STAT);

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	logic [3:0] fth_r;
	logic [5:0] pcg_r;
	logic [5:0] pcp_r;
	logic [15:0] clk_r;
	logic [7:0] freq_r;
	logic [7:0] mode_r;
	logic [7:0] avg_r;
	logic [7:0] mask_r;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fth_r <= 4'h0;
			pcg_r <= sfr_pkg::PC_RST;
			pcp_r <= sfr_pkg::PC_RST;
			clk_r <= sfr_pkg::CLK_RST;
			freq_r <= 8'h00;
			mode_r <= {4'h0, sfr_pkg::MODE_STBY};
			avg_r <= 8'h00;
			mask_r <= sfr_pkg::MASK_RST;
		end else begin
			if (we_fth) fth_r <= wdata[sfr_pkg::FTH_LSB +: 4];
			if (we_pcg) pcg_r <= wdata[sfr_pkg::PC_LSB +: 6];
			if (we_pcp) pcp_r <= wdata[sfr_pkg::PC_LSB +: 6];
			if (we_clk) clk_r <= wdata;
			if (we_freq) freq_r <= wdata[7:0];
			if (we_mode) mode_r <= wdata[7:0];
			if (we_avg) avg_r <= {1'b0, wdata[6:4], 1'b0, wdata[2:0]};
			if (we_mask) mask_r <= wdata[7:0];
		end
	end

	logic [3:0] mode_sel;
	logic [3:0] fmt_sel;
	logic gest_mode;
	logic prox_mode;
	logic sampling;
	logic forced;
	logic [3:0] freq_sel;
	logic [2:0] avg_sel;
	logic [5:0] pc_sel;
	logic [7:0] n_w;
	logic [15:0] period_w;

	// mode-dependent selections
	assign mode_sel = mode_r[sfr_pkg::MODE_LSB +: 4];
	assign fmt_sel = mode_r[sfr_pkg::FMT_LSB +: 4];
	assign gest_mode = (mode_sel == sfr_pkg::MODE_GEST);
	assign prox_mode = (mode_sel == sfr_pkg::MODE_PROX);
	assign sampling = gest_mode | prox_mode;
	assign forced = (clk_r == sfr_pkg::CLK_FORCE);
	assign freq_sel = gest_mode ? freq_r[sfr_pkg::FREQ_GEST_LSB +: 4] : freq_r[sfr_pkg::FREQ_PROX_LSB +: 4];
	assign avg_sel = gest_mode ? avg_r[sfr_pkg::AVG_GEST_LSB +: 3] : avg_r[sfr_pkg::AVG_PROX_LSB +: 3];
	assign pc_sel = gest_mode ? pcg_r : pcp_r;
	assign n_w = 8'h01 << avg_sel;
	assign period_w = 16'(SLOT_UNIT_CYC * (16 - int'(freq_sel)));

	// ****************************************************************
	// sample sequencer
	// ****************************************************************
	sfr_pkg::sfr_samp_t st_r;
	sfr_pkg::sfr_samp_t st_nxt;
	logic [15:0] tmr_r;
	logic [6:0] nsum_r;
	logic last_w;
	logic conv_done;
	logic upd;
	logic afe_start_r;
	logic [5:0] afe_pulses_r;
	logic [13:0] eff_pulses_r;

	// output sample completes after n summed internal samples
	assign last_w = (nsum_r == 7'(n_w - 8'h01));
	assign conv_done = (st_r == sfr_pkg::SS_CONV) && afe_done && sampling;
	assign upd = conv_done && last_w;

	// next state: idle or standby parks the sequencer
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			sfr_pkg::SS_OFF: begin
				if (sampling) st_nxt = sfr_pkg::SS_TICK;
			end
			sfr_pkg::SS_TICK: begin
				if (!sampling) st_nxt = sfr_pkg::SS_OFF;
				else if (tmr_r == 16'h0000) st_nxt = sfr_pkg::SS_CONV;
			end
			sfr_pkg::SS_CONV: begin
				if (!sampling) st_nxt = sfr_pkg::SS_OFF;
				else if (afe_done) st_nxt = sfr_pkg::SS_TICK;
			end
		endcase
	end

	// state, slot timer and converter request
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_r <= sfr_pkg::SS_OFF;
			tmr_r <= 16'h0000;
			afe_start_r <= 1'b0;
			afe_pulses_r <= 6'h00;
			eff_pulses_r <= 14'h0000;
		end else begin
			st_r <= st_nxt;
			tmr_r <= (st_r != sfr_pkg::SS_TICK) ? period_w - 16'h0001 : tmr_r - 16'h0001;
			afe_start_r <= (st_r == sfr_pkg::SS_TICK) && sampling && (tmr_r == 16'h0000);
			afe_pulses_r <= pc_sel;
			eff_pulses_r <= 14'(pc_sel) * 14'(n_w);
		end
	end

	// summed sample counter
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			nsum_r <= 7'h00;
		end else if (st_r == sfr_pkg::SS_OFF || upd) begin
			nsum_r <= 7'h00;
		end else if (conv_done) begin
			nsum_r <= nsum_r + 7'h01;
		end
	end

	logic [3:0][SUM_W-1:0] acc_r;
	logic [3:0][SUM_W-1:0] sum_w;
	logic [3:0][15:0] sat_w;

	// per-channel accumulate and clip
	for (genvar g = 0; g < 4; g++) begin : g_ch
		assign sum_w[g] = acc_r[g] + SUM_W'(afe_res.ch[g]);
		assign sat_w[g] = (|sum_w[g][SUM_W-1:16]) ? 16'hFFFF : sum_w[g][15:0];
		always_ff @(posedge clk_sys or posedge reset) begin
			if (reset) begin
				acc_r[g] <= '0;
			end else if (st_r == sfr_pkg::SS_OFF || upd) begin
				acc_r[g] <= '0;
			end else if (conv_done) begin
				acc_r[g] <= sum_w[g];
			end
		end
	end

	// ****************************************************************
	// result registers
	// ****************************************************************
	logic [6:0][15:0] res_r;

	// gesture fills four channels, proximity fills intensity, x, y
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			res_r <= '0;
		end else if (upd) begin
			for (int i = 0; i < 4; i++) begin
				if (gest_mode) res_r[i] <= sat_w[i];
			end
			for (int i = 0; i < 3; i++) begin
				if (prox_mode) res_r[i + 4] <= sat_w[i];
			end
		end
	end

	// ****************************************************************
	// packet fifo
	// ****************************************************************
	logic [7:0] mem_r [FIFO_BYTES];
	logic [PTR_W-1:0] wptr_r;
	logic [PTR_W-1:0] rptr_r;
	logic [CNT_W-1:0] cnt_r;
	logic [2:0] pkt_len;
	logic [47:0] pkt_w;
	logic room_ok;
	logic push;
	logic rd_data;
	logic [1:0] pop_n;
	logic flush_go;
	logic [CNT_W-1:0] words_w;

	// packet length from mode and format; zero means no capture
	assign pkt_len = (gest_mode && fmt_sel == sfr_pkg::FMT_GEST) ? sfr_pkg::PKT_GEST :
		(prox_mode && fmt_sel == sfr_pkg::FMT_PROX_I) ? sfr_pkg::PKT_PROX_I :
		(prox_mode && fmt_sel == sfr_pkg::FMT_PROX_IXY) ? sfr_pkg::PKT_PROX_IXY : 3'h0;
	assign pkt_w = {sat_w[0], sat_w[1], sat_w[2]}; // high byte first
	assign room_ok = (CNT_W'(FIFO_BYTES) - cnt_r) >= CNT_W'(pkt_len);
	assign push = upd && (pkt_len != 3'h0) && room_ok;
	assign rd_data = rd_go && (addr == sfr_pkg::ADDR_DATA) && forced;
	assign pop_n = !rd_data ? 2'h0 : (cnt_r >= CNT_W'(2)) ? 2'h2 : (cnt_r != '0) ? 2'h1 : 2'h0;
	assign flush_go = we_stat && wdata[sfr_pkg::FLUSH_BIT] && (mode_sel == sfr_pkg::MODE_IDLE) && forced;
	assign words_w = cnt_r >> 1;

	// pointers and fill count; flush beats any push or pop
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
		end else if (flush_go) begin
			wptr_r <= '0;
			rptr_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) wptr_r <= wptr_r + PTR_W'(pkt_len);
			rptr_r <= rptr_r + PTR_W'(pop_n);
			cnt_r <= cnt_r + (push ? CNT_W'(pkt_len) : CNT_W'(0)) - CNT_W'(pop_n);
		end
	end

	// whole packet written in one cycle
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < 6; i++) begin
			if (push && i < int'(pkt_len)) mem_r[wptr_r + PTR_W'(i)] <= pkt_w[47 - 8 * i -: 8];
		end
	end

	// ****************************************************************
	// status, flags and interrupt pin
	// ****************************************************************
	logic [1:0] flags_r;
	logic [1:0] set_w;
	logic clr_w;
	logic fifo_flag_r;
	logic [7:0] stat_low;
	logic int_r;
	logic fast_clk_on_r;

	assign set_w = {upd & prox_mode, upd & gest_mode};
	assign clr_w = we_stat && (wdata[7:0] == 8'h00);
	assign stat_low = {fifo_flag_r, 5'h00, flags_r};

	// sticky sample flags, set wins over clear; fifo flag follows level
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			flags_r <= 2'h0;
			fifo_flag_r <= 1'b0;
			int_r <= 1'b0;
			fast_clk_on_r <= 1'b0;
		end else begin
			flags_r <= (flags_r & ~{2{clr_w}}) | set_w;
			fifo_flag_r <= !flush_go && (words_w > CNT_W'(fth_r));
			int_r <= |(stat_low & ~mask_r);
			fast_clk_on_r <= forced;
		end
	end

	// ****************************************************************
	// read mux and answer toggle
	// ****************************************************************
	logic [15:0] data_word;
	logic [15:0] rdata_w;

	assign data_word = !forced || cnt_r == '0 ? 16'h0000 :
		{mem_r[rptr_r], (cnt_r >= CNT_W'(2)) ? mem_r[rptr_r + PTR_W'(1)] : 8'h00};
	assign rdata_w = (addr <= sfr_pkg::ADDR_RES_LAST) ? res_r[addr[2:0]] :
		(addr == sfr_pkg::ADDR_FTH) ? {4'h0, fth_r, 8'h00} :
		(addr == sfr_pkg::ADDR_PCG) ? {2'h0, pcg_r, 8'h00} :
		(addr == sfr_pkg::ADDR_PCP) ? {2'h0, pcp_r, 8'h00} :
		(addr == sfr_pkg::ADDR_CLK) ? clk_r :
		(addr == sfr_pkg::ADDR_FREQ) ? {8'h00, freq_r} :
		(addr == sfr_pkg::ADDR_MODE) ? {8'h00, mode_r} :
		(addr == sfr_pkg::ADDR_AVG) ? {8'h00, avg_r} :
		(addr == sfr_pkg::ADDR_MASK) ? {8'h00, mask_r} :
		(addr == sfr_pkg::ADDR_STAT) ? {1'b0, 7'(cnt_r), stat_low} :
		(addr == sfr_pkg::ADDR_DATA) ? data_word : 16'h0000;

	// request toggle crossing and answer capture
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rq_s1_r <= 1'b0;
			rq_s2_r <= 1'b0;
			rq_s3_r <= 1'b0;
			ack_tgl_r <= 1'b0;
			sys_rdata_r <= 16'h0000;
		end else begin
			rq_s1_r <= rq_tgl_r;
			rq_s2_r <= rq_s1_r;
			rq_s3_r <= rq_s2_r;
			if (acc_go) begin
				sys_rdata_r <= rd_go ? rdata_w : 16'h0000;
				ack_tgl_r <= ~ack_tgl_r;
			end
		end
	end

	assign afe_start = afe_start_r;
	assign afe_pulses = afe_pulses_r;
	assign eff_pulses = eff_pulses_r;
	assign fast_clk_on = fast_clk_on_r;
	assign int_out = int_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	property p_fifo_drop;
		(words_w <= CNT_W'(fth_r)) |=> !fifo_flag_r;
	endproperty
	a_fifo_drop: assert property (p_fifo_drop) else $error("fifo flag held below threshold");

	property p_fifo_rise;
		(words_w > CNT_W'(fth_r)) && !flush_go |=> fifo_flag_r ##1 (int_out || $past(mask_r[7]));
	endproperty
	a_fifo_rise: assert property (p_fifo_rise) else $error("fifo flag missed threshold");

	property p_pop;
		rd_data && cnt_r >= CNT_W'(2) && !push && !flush_go |=> cnt_r == $past(cnt_r) - CNT_W'(2);
	endproperty
	a_pop: assert property (p_pop) else $error("data port read did not free two bytes");

	property p_push;
		push && pop_n == 2'h0 && !flush_go |=> cnt_r == $past(cnt_r) + CNT_W'($past(pkt_len));
	endproperty
	a_push: assert property (p_push) else $error("fill count not raised by packet length");

	property p_drop;
		upd && !room_ok && pop_n == 2'h0 && !flush_go |=> cnt_r == $past(cnt_r) && wptr_r == $past(wptr_r);
	endproperty
	a_drop: assert property (p_drop) else $error("partial packet stored");

	property p_flush;
		flush_go |=> cnt_r == '0 ##1 !fifo_flag_r;
	endproperty
	a_flush: assert property (p_flush) else $error("flush left data or flag");

	property p_idle;
		(mode_sel == sfr_pkg::MODE_IDLE) ##1 (mode_sel == sfr_pkg::MODE_IDLE) |=> !afe_start && st_r == sfr_pkg::SS_OFF;
	endproperty
	a_idle: assert property (p_idle) else $error("sampling continued in idle");

	property p_update;
		upd && gest_mode |=> flags_r[0] && res_r[0] == $past(sat_w[0]) && res_r[3] == $past(sat_w[3]);
	endproperty
	a_update: assert property (p_update) else $error("results or flag not updated together");

	property p_clip;
		upd && gest_mode && (|sum_w[1][SUM_W-1:16]) |=> res_r[1] == 16'hFFFF;
	endproperty
	a_clip: assert property (p_clip) else $error("result wrapped instead of clipping");

	property p_irq;
		upd && gest_mode && !mask_r[0] |=> ##1 int_out;
	endproperty
	a_irq: assert property (p_irq) else $error("enabled sample interrupt not raised");

	property p_masked;
		(mask_r == 8'hFF) ##1 (mask_r == 8'hFF) |=> !int_out;
	endproperty
	a_masked: assert property (p_masked) else $error("masked interrupt reached pin");

	property p_clear;
		clr_w && !upd |=> flags_r == 2'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("status clear left flags set");

	c_push: cover property (push ##[1:200] rd_data);
	c_drop: cover property (upd && !room_ok);
	c_flush: cover property (flush_go);
	c_clip: cover property (upd && sat_w[0] == 16'hFFFF);
endmodule
